// ==== logic/prog_ctrl_pkg.sv ====
// shared constants and types for the program-control unit
package prog_ctrl_pkg;
  localparam int PC_W = 14;
  localparam int SP_W = 8;
  localparam logic [13:0] RESET_PC = 14'h0000;
  localparam logic [13:0] VEC_BASE = 14'h0002;
  localparam logic [13:0] VEC_LAST = 14'h0018;
  localparam logic [13:0] PROG_FIRST = 14'h001A;
  localparam logic [13:0] PROG_LAST = 14'h1FDF;
  localparam logic [3:0] NUM_VECTORS = 4'hC;
  localparam int RAM_BYTES = 256;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] PC_STEP = 8'h01;
  localparam logic [5:0] PAGE_STEP = 6'h01;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_POR_BIT = 4;
  localparam int STAT_WDT_BIT = 6;
  localparam logic [7:0] STAT_POR_VALUE = 8'h11;
  localparam logic [7:0] STAT_WDT_VALUE = 8'h41;
  localparam logic [7:0] STAT_KEEP_ON_WDT = 8'h10;

  typedef enum logic [3:0] {
    OP_ADVANCE,
    OP_PAGE,
    OP_JUMP,
    OP_CALL,
    OP_RET,
    OP_RETURN_FROM_INTERRUPT,
    OP_PUSH,
    OP_POP,
    OP_LOAD_SP,
    OP_DI,
    OP_EI,
    OP_OPERAND
  } op_t;

  typedef enum logic [1:0] {
    MODE_IMM,
    MODE_DIRECT,
    MODE_INDEXED
  } mode_t;
endpackage

// ==== logic/prog_ctrl.sv ====
// program counter, stacks, vectors, addressing and reset cause of the core
// Notes on behaviour
// - any reset restarts fetch at address zero
// - interrupts jump to even vectors 0x0002..0x0018
// - program code spans 0x001A to 0x1FDF
// - program stack pointer resets zero, grows upward
// - stack pointer loaded from accumulator, never readable
// - interrupt entry disables, pushes two bytes post-increment
// - return-from-interrupt pops two bytes, then enables
// - call pushes counter and flags, pointer plus two
// - plain return restores counter only, pointer minus two
// - data space is 256 bytes of shared RAM
// - push pre-decrements data pointer then writes
// - pop reads then post-increments data pointer
// - push at pointer zero writes address 0xFF
// - immediate operand is the second instruction byte
// - direct operand address is the second byte
// - indexed address is constant plus index register
// - every reset restores pc and stack pointers, disables interrupts
// - status bit 4 power-on, bit 6 watchdog
// - reset entry pushes nothing onto the stack
// - fetch bumps low byte, page advance both upper and low
module prog_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic watchdog_reset_i,
  input wire logic cmd_valid_i,
  input wire prog_ctrl_pkg::op_t cmd_op_i,
  input wire logic [13:0] target_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] index_i,
  input wire logic [7:0] operand_byte_i,
  input wire prog_ctrl_pkg::mode_t mode_i,
  input wire logic carry_i,
  input wire logic zero_i,
  input wire logic irq_valid_i,
  input wire logic [3:0] irq_index_i,
  input wire logic [7:0] status_clr_i,
  input wire logic [7:0] ram_rdata_i,
  output logic cmd_ready_o,
  output logic irq_ack_o,
  output logic done_o,
  output logic [13:0] program_counter_o,
  output logic pc_fault_o,
  output logic int_enable_o,
  output logic carry_o,
  output logic zero_o,
  output logic flags_load_o,
  output logic [7:0] pop_data_o,
  output logic pop_valid_o,
  output logic [7:0] operand_o,
  output logic operand_is_addr_o,
  output logic operand_valid_o,
  output logic [7:0] status_o,
  output logic usb_addr_clear_o,
  output logic [7:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic ram_we_o,
  output logic ram_re_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH2,
    ST_PUSH_END,
    ST_POP2,
    ST_POP_HI,
    ST_POP_LO,
    ST_DPOP_WAIT,
    ST_DPOP_CAP
  } state_t;

  state_t state;
  logic [13:0] pc;
  logic [13:0] next_pc;
  logic [13:0] jump_target;
  logic [7:0] program_stack_pointer;
  logic [7:0] data_stack_pointer;
  logic [7:0] hi_byte;
  logic is_return_from_interrupt;
  logic take_irq;
  logic take_cmd;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  function automatic logic [13:0] vector_of(input logic [3:0] idx);
    vector_of = prog_ctrl_pkg::VEC_BASE + {9'h000, idx, 1'b0};
  endfunction

  assign take_irq = (state == ST_IDLE) && int_enable_o && irq_valid_i
    && (irq_index_i < prog_ctrl_pkg::NUM_VECTORS) && !watchdog_reset_i;
  assign take_cmd = (state == ST_IDLE) && cmd_valid_i && !take_irq && !watchdog_reset_i;
  assign cmd_ready_o = (state == ST_IDLE) && !take_irq;
  assign program_counter_o = pc;

  // --------------------------------------------------------------
  // program counter
  // --------------------------------------------------------------
  always_comb
  begin
    next_pc = pc;
    if (take_cmd)
    begin
      case (cmd_op_i)
        prog_ctrl_pkg::OP_ADVANCE: next_pc = {pc[13:8], pc[7:0] + prog_ctrl_pkg::PC_STEP};
        prog_ctrl_pkg::OP_PAGE:
          next_pc = {pc[13:8] + prog_ctrl_pkg::PAGE_STEP, pc[7:0] + prog_ctrl_pkg::PC_STEP};
        prog_ctrl_pkg::OP_JUMP: next_pc = target_i;
        default: next_pc = pc;
      endcase
    end
    else if (state == ST_PUSH_END)
      next_pc = jump_target;
    else if (state == ST_POP_LO)
      next_pc = {hi_byte[5:0], ram_rdata_i};
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc <= prog_ctrl_pkg::RESET_PC;
      pc_fault_o <= 1'b0;
      jump_target <= prog_ctrl_pkg::RESET_PC;
    end
    else if (watchdog_reset_i)
    begin
      pc <= prog_ctrl_pkg::RESET_PC;
      pc_fault_o <= 1'b0;
      jump_target <= prog_ctrl_pkg::RESET_PC;
    end
    else
    begin
      pc <= next_pc;
      pc_fault_o <= next_pc > prog_ctrl_pkg::PROG_LAST;
      if (take_irq)
        jump_target <= vector_of(irq_index_i);
      else if (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_CALL)
        jump_target <= target_i;
    end
  end

  // --------------------------------------------------------------
  // sequencer and RAM port
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      ram_addr_o <= 8'h00;
      ram_wdata_o <= 8'h00;
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      hi_byte <= 8'h00;
      is_return_from_interrupt <= 1'b0;
      pop_data_o <= 8'h00;
    end
    else if (watchdog_reset_i)
    begin
      state <= ST_IDLE;
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      is_return_from_interrupt <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          ram_we_o <= 1'b0;
          ram_re_o <= 1'b0;
          if (take_irq || (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_CALL))
          begin
            ram_addr_o <= program_stack_pointer;
            ram_wdata_o <= pc[7:0];
            ram_we_o <= 1'b1;
            state <= ST_PUSH2;
          end
          else if (take_cmd)
          begin
            case (cmd_op_i)
              prog_ctrl_pkg::OP_RET, prog_ctrl_pkg::OP_RETURN_FROM_INTERRUPT:
              begin
                ram_addr_o <= program_stack_pointer - prog_ctrl_pkg::SP_STEP;
                ram_re_o <= 1'b1;
                is_return_from_interrupt <= cmd_op_i == prog_ctrl_pkg::OP_RETURN_FROM_INTERRUPT;
                state <= ST_POP2;
              end
              prog_ctrl_pkg::OP_PUSH:
              begin
                ram_addr_o <= data_stack_pointer - prog_ctrl_pkg::SP_STEP;
                ram_wdata_o <= acc_i;
                ram_we_o <= 1'b1;
              end
              prog_ctrl_pkg::OP_POP:
              begin
                ram_addr_o <= data_stack_pointer;
                ram_re_o <= 1'b1;
                state <= ST_DPOP_WAIT;
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_PUSH2:
        begin
          ram_addr_o <= program_stack_pointer + prog_ctrl_pkg::SP_STEP;
          ram_wdata_o <= {carry_i, zero_i, pc[13:8]};
          state <= ST_PUSH_END;
        end
        ST_PUSH_END:
        begin
          ram_we_o <= 1'b0;
          state <= ST_IDLE;
        end
        ST_POP2:
        begin
          ram_addr_o <= program_stack_pointer - prog_ctrl_pkg::SP_STEP - prog_ctrl_pkg::SP_STEP;
          state <= ST_POP_HI;
        end
        ST_POP_HI:
        begin
          hi_byte <= ram_rdata_i;
          ram_re_o <= 1'b0;
          state <= ST_POP_LO;
        end
        ST_POP_LO: state <= ST_IDLE;
        ST_DPOP_WAIT:
        begin
          ram_re_o <= 1'b0;
          state <= ST_DPOP_CAP;
        end
        ST_DPOP_CAP:
        begin
          pop_data_o <= ram_rdata_i;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // stack pointers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      program_stack_pointer <= prog_ctrl_pkg::SP_RESET;
      data_stack_pointer <= prog_ctrl_pkg::SP_RESET;
    end
    else if (watchdog_reset_i)
    begin
      program_stack_pointer <= prog_ctrl_pkg::SP_RESET;
      data_stack_pointer <= prog_ctrl_pkg::SP_RESET;
    end
    else
    begin
      if (state == ST_PUSH2 || state == ST_PUSH_END)
        program_stack_pointer <= program_stack_pointer + prog_ctrl_pkg::SP_STEP;
      else if (state == ST_POP2 || state == ST_POP_HI)
        program_stack_pointer <= program_stack_pointer - prog_ctrl_pkg::SP_STEP;
      else if (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_LOAD_SP)
        program_stack_pointer <= acc_i;
      if (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_PUSH)
        data_stack_pointer <= data_stack_pointer - prog_ctrl_pkg::SP_STEP;
      else if (state == ST_DPOP_CAP)
        data_stack_pointer <= data_stack_pointer + prog_ctrl_pkg::SP_STEP;
    end
  end

  // --------------------------------------------------------------
  // interrupt enable, flags, handshakes
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_enable_o <= 1'b0;
      carry_o <= 1'b0;
      zero_o <= 1'b0;
      flags_load_o <= 1'b0;
      irq_ack_o <= 1'b0;
      done_o <= 1'b0;
      pop_valid_o <= 1'b0;
    end
    else if (watchdog_reset_i)
    begin
      int_enable_o <= 1'b0;
      flags_load_o <= 1'b0;
      irq_ack_o <= 1'b0;
      done_o <= 1'b0;
      pop_valid_o <= 1'b0;
    end
    else
    begin
      irq_ack_o <= take_irq;
      flags_load_o <= 1'b0;
      done_o <= state == ST_PUSH_END || state == ST_POP_LO || state == ST_DPOP_CAP;
      pop_valid_o <= state == ST_DPOP_CAP;
      if (take_irq || (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_DI))
        int_enable_o <= 1'b0;
      else if (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_EI)
        int_enable_o <= 1'b1;
      else if (state == ST_POP_LO && is_return_from_interrupt)
        int_enable_o <= 1'b1;
      if (state == ST_POP_LO && is_return_from_interrupt)
      begin
        carry_o <= hi_byte[7];
        zero_o <= hi_byte[6];
        flags_load_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // operand addressing
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      operand_o <= 8'h00;
      operand_is_addr_o <= 1'b0;
      operand_valid_o <= 1'b0;
    end
    else
    begin
      operand_valid_o <= take_cmd && cmd_op_i == prog_ctrl_pkg::OP_OPERAND;
      if (take_cmd && cmd_op_i == prog_ctrl_pkg::OP_OPERAND)
      begin
        operand_o <= (mode_i == prog_ctrl_pkg::MODE_INDEXED) ? operand_byte_i + index_i
          : operand_byte_i;
        operand_is_addr_o <= mode_i != prog_ctrl_pkg::MODE_IMM;
      end
    end
  end

  // --------------------------------------------------------------
  // reset cause
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_o <= prog_ctrl_pkg::STAT_POR_VALUE;
      usb_addr_clear_o <= 1'b1;
    end
    else
    begin
      usb_addr_clear_o <= watchdog_reset_i;
      if (watchdog_reset_i)
        status_o <= (status_o & prog_ctrl_pkg::STAT_KEEP_ON_WDT) | prog_ctrl_pkg::STAT_WDT_VALUE;
      else
        status_o <= status_o & ~status_clr_i;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_reset_pc;
    @(posedge core_clk_i) disable iff (rst_i)
    watchdog_reset_i |=> pc == 14'h0000 && program_stack_pointer == 8'h00;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not cleared");
  property p_vector;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_irq |-> ##3 pc == 14'h0002 + {9'h000, $past(irq_index_i, 3), 1'b0};
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");
  property p_fault;
    @(posedge core_clk_i) disable iff (rst_i)
    pc_fault_o == (pc > 14'h1FDF);
  endproperty
  a_fault: assert property (p_fault) else $error("program range flag wrong");
  property p_entry;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_irq |=> !int_enable_o && ram_we_o && ram_addr_o == $past(program_stack_pointer);
  endproperty
  a_entry: assert property (p_entry) else $error("bad interrupt entry");
  property p_call;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_CALL
      |-> ##3 program_stack_pointer == $past(program_stack_pointer, 3) + 8'h02;
  endproperty
  a_call: assert property (p_call) else $error("call pointer step wrong");
  property p_ret;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_RET
      |-> ##4 carry_o == $past(carry_o, 4) && zero_o == $past(zero_o, 4)
      && program_stack_pointer == $past(program_stack_pointer, 4) - 8'h02;
  endproperty
  a_ret: assert property (p_ret) else $error("return touched flags");
  property p_return_from_interrupt;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_RETURN_FROM_INTERRUPT && !int_enable_o
      |=> !int_enable_o [*3] ##1 int_enable_o;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("enable timing wrong");
  property p_push;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_PUSH
      |=> ram_we_o && ram_addr_o == $past(data_stack_pointer) - 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push address wrong");
  property p_pop;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_POP
      |=> ram_addr_o == $past(data_stack_pointer) ##2
      data_stack_pointer == $past(data_stack_pointer, 3) + 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop order wrong");
  property p_load_sp;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_LOAD_SP |=> program_stack_pointer == $past(acc_i);
  endproperty
  a_load_sp: assert property (p_load_sp) else $error("pointer load lost");
  property p_wdt;
    @(posedge core_clk_i) disable iff (rst_i)
    watchdog_reset_i |=> status_o[6] && !ram_we_o && !int_enable_o && state == ST_IDLE;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset effects wrong");
  property p_page;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_ADVANCE |=> pc[13:8] == $past(pc[13:8]);
  endproperty
  a_page: assert property (p_page) else $error("page moved on fetch");
  property p_index;
    @(posedge core_clk_i) disable iff (rst_i || watchdog_reset_i)
    take_cmd && cmd_op_i == prog_ctrl_pkg::OP_OPERAND && mode_i == prog_ctrl_pkg::MODE_INDEXED
      |=> operand_o == $past(operand_byte_i) + $past(index_i) && operand_is_addr_o;
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");
  c_irq: cover property (@(posedge core_clk_i) disable iff (rst_i) take_irq ##3 done_o);
  c_return_from_interrupt: cover property (@(posedge core_clk_i) disable iff (rst_i) flags_load_o);
  c_wrap: cover property (@(posedge core_clk_i) disable iff (rst_i)
    ram_we_o && ram_addr_o == 8'hFF);
endmodule

// ==== tb/ram_model.sv ====
// synchronous 256-byte data RAM facing the program-control unit
module ram_model (
  input wire logic core_clk_i,
  input wire logic [7:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  input wire logic ram_we_i,
  input wire logic ram_re_i,
  output logic [7:0] ram_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] rd = 8'h00;
  assign ram_rdata_o = rd;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'hA5;
  end
  always @(posedge core_clk_i)
  begin
    if (ram_we_i)
      mem[ram_addr_i] <= ram_wdata_i;
  end
  // data stands one cycle after a read, then the line toggles
  always @(posedge core_clk_i)
  begin
    if (ram_re_i)
      rd <= mem[ram_addr_i];
    else
      rd <= ~rd;
  end
endmodule

// ==== tb/prog_ctrl_tb.sv ====
// self-checking bench for the program-control unit
module prog_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic watchdog_reset_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  prog_ctrl_pkg::op_t cmd_op_i = prog_ctrl_pkg::OP_ADVANCE;
  prog_ctrl_pkg::mode_t mode_i = prog_ctrl_pkg::MODE_IMM;
  logic [13:0] target_i = 14'h0000;
  logic [7:0] acc_i = 8'h00, index_i = 8'h00, operand_byte_i = 8'h00, status_clr_i = 8'h00;
  logic carry_i = 1'b0, zero_i = 1'b0, irq_valid_i = 1'b0;
  logic [3:0] irq_index_i = 4'h0;
  logic [7:0] ram_rdata_i, pop_data_o, operand_o, status_o, ram_addr_o, ram_wdata_o;
  logic cmd_ready_o, irq_ack_o, done_o, pc_fault_o, int_enable_o, carry_o, zero_o;
  logic flags_load_o, pop_valid_o, operand_is_addr_o, operand_valid_o, usb_addr_clear_o;
  logic ram_we_o, ram_re_o;
  logic [13:0] program_counter_o;
  int n_fail = 0;
  int comparisons = 0;
  int n_wr = 0;
  int seed = 89441;

  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (ram_we_o === 1'b1) n_wr++;

  prog_ctrl i_prog_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .watchdog_reset_i(watchdog_reset_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .target_i(target_i), .acc_i(acc_i), .index_i(index_i), .operand_byte_i(operand_byte_i),
    .mode_i(mode_i), .carry_i(carry_i), .zero_i(zero_i), .irq_valid_i(irq_valid_i),
    .irq_index_i(irq_index_i), .status_clr_i(status_clr_i), .ram_rdata_i(ram_rdata_i),
    .cmd_ready_o(cmd_ready_o), .irq_ack_o(irq_ack_o), .done_o(done_o),
    .program_counter_o(program_counter_o), .pc_fault_o(pc_fault_o),
    .int_enable_o(int_enable_o), .carry_o(carry_o), .zero_o(zero_o),
    .flags_load_o(flags_load_o), .pop_data_o(pop_data_o), .pop_valid_o(pop_valid_o),
    .operand_o(operand_o), .operand_is_addr_o(operand_is_addr_o),
    .operand_valid_o(operand_valid_o), .status_o(status_o),
    .usb_addr_clear_o(usb_addr_clear_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o), .ram_we_o(ram_we_o), .ram_re_o(ram_re_o));

  ram_model i_ram_model (.core_clk_i(core_clk_i), .ram_addr_i(ram_addr_o),
    .ram_wdata_i(ram_wdata_o), .ram_we_i(ram_we_o), .ram_re_i(ram_re_o),
    .ram_rdata_o(ram_rdata_i));

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pc(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // drivers, all acting at the falling edge
  // ----------------------------------------
  function automatic logic sig(input int w);
    case (w)
      0: return cmd_ready_o;
      1: return done_o;
      2: return irq_ack_o;
      default: return operand_valid_o;
    endcase
  endfunction

  task automatic wait_on(input int w);
    int i;
    i = 0;
    while (sig(w) !== 1'b1)
    begin
      @(negedge core_clk_i);
      i++;
      if (i > 40)
      begin
        n_fail++;
        print_verdict();
      end
    end
  endtask

  task automatic cmd(input prog_ctrl_pkg::op_t op);
    wait_on(0);
    cmd_op_i = op;
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic jump(input logic [13:0] t);
    target_i = t;
    cmd(prog_ctrl_pkg::OP_JUMP);
  endtask

  task automatic push(input logic [7:0] v);
    acc_i = v;
    cmd(prog_ctrl_pkg::OP_PUSH);
    @(negedge core_clk_i);
  endtask

  task automatic pop(input logic [7:0] exp);
    cmd_op_i = prog_ctrl_pkg::OP_POP;
    wait_on(0);
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    wait_on(1);
    chk_bit(pop_valid_o, 1'b1);
    chk_byte(pop_data_o, exp);
  endtask

  task automatic multi(input prog_ctrl_pkg::op_t op);
    cmd_op_i = op;
    wait_on(0);
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    wait_on(1);
    @(negedge core_clk_i);
  endtask

  function automatic logic [7:0] mem_at(input logic [7:0] a);
    return i_ram_model.mem[a];
  endfunction

  function automatic logic [13:0] rnd_pc();
    return 14'h0100 + 14'($unsigned($random(seed)) % 32'h1E00);
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [13:0] p, t;
    logic [7:0] v, w, sp, ev;
    logic c, z;
    int w0;
    v = 8'($random(seed));
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk_pc(program_counter_o, prog_ctrl_pkg::RESET_PC);
    chk_byte(status_o, prog_ctrl_pkg::STAT_POR_VALUE);
    chk_bit(int_enable_o, 1'b0);
    chk_bit(usb_addr_clear_o, 1'b1);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    // data stack from its reset position
    w = 8'($random(seed));
    push(v);
    push(w);
    chk_byte(mem_at(8'hFF), v);
    chk_byte(mem_at(8'hFE), w);
    pop(w);
    pop(v);
    push(~v);
    chk_byte(mem_at(8'hFF), ~v);
    pop(~v);
    // operand addressing in all modes
    for (int k = 0; k < 24; k++)
    begin
      mode_i = prog_ctrl_pkg::mode_t'(k % 3);
      operand_byte_i = 8'($random(seed));
      index_i = 8'($random(seed));
      ev = (mode_i == prog_ctrl_pkg::MODE_INDEXED) ? operand_byte_i + index_i : operand_byte_i;
      cmd_op_i = prog_ctrl_pkg::OP_OPERAND;
      wait_on(0);
      cmd_valid_i = 1'b1;
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      wait_on(3);
      chk_byte(operand_o, ev);
      chk_bit(operand_is_addr_o, mode_i != prog_ctrl_pkg::MODE_IMM);
      @(negedge core_clk_i);
    end
    // sequential fetch and page advance
    p = {6'($unsigned($random(seed)) % 32'h1E), 8'hFE};
    jump(p);
    cmd(prog_ctrl_pkg::OP_ADVANCE);
    chk_pc(program_counter_o, p + 14'h0001);
    cmd(prog_ctrl_pkg::OP_ADVANCE);
    chk_pc(program_counter_o, {p[13:8], 8'h00});
    cmd(prog_ctrl_pkg::OP_PAGE);
    chk_pc(program_counter_o, {p[13:8] + 6'h01, 8'h01});
    jump(prog_ctrl_pkg::PROG_LAST);
    @(negedge core_clk_i);
    chk_bit(pc_fault_o, 1'b0);
    jump(prog_ctrl_pkg::PROG_LAST + 14'h0001);
    @(negedge core_clk_i);
    chk_bit(pc_fault_o, 1'b1);
    // call and plain return at a loaded stack pointer
    sp = 8'($random(seed));
    acc_i = sp;
    cmd(prog_ctrl_pkg::OP_LOAD_SP);
    p = rnd_pc();
    t = rnd_pc();
    jump(p);
    c = carry_o;
    carry_i = ~c;
    zero_i = 1'b1;
    target_i = t;
    multi(prog_ctrl_pkg::OP_CALL);
    chk_pc(program_counter_o, t);
    chk_byte(mem_at(sp), p[7:0]);
    chk_byte(mem_at(sp + 8'h01), {~c, 1'b1, p[13:8]});
    multi(prog_ctrl_pkg::OP_RET);
    chk_pc(program_counter_o, p);
    chk_bit(carry_o, c);
    // every vector, each entry and return
    for (int k = 0; k < 12; k++)
    begin
      cmd(prog_ctrl_pkg::OP_EI);
      p = rnd_pc();
      jump(p);
      c = 1'($random(seed));
      z = 1'($random(seed));
      carry_i = c;
      zero_i = z;
      irq_index_i = 4'(k);
      irq_valid_i = 1'b1;
      wait_on(2);
      irq_valid_i = 1'b0;
      chk_bit(int_enable_o, 1'b0);
      wait_on(1);
      @(negedge core_clk_i);
      chk_pc(program_counter_o, prog_ctrl_pkg::VEC_BASE + 14'(2 * k));
      chk_byte(mem_at(sp), p[7:0]);
      chk_byte(mem_at(sp + 8'h01), {c, z, p[13:8]});
      carry_i = ~c;
      zero_i = ~z;
      multi(prog_ctrl_pkg::OP_RETURN_FROM_INTERRUPT);
      chk_pc(program_counter_o, p);
      chk_bit(carry_o, c);
      chk_bit(zero_o, z);
      chk_bit(int_enable_o, 1'b1);
    end
    // watchdog reset in mid-run
    push(8'h3C);
    w0 = n_wr;
    watchdog_reset_i = 1'b1;
    @(negedge core_clk_i);
    watchdog_reset_i = 1'b0;
    chk_pc(program_counter_o, prog_ctrl_pkg::RESET_PC);
    chk_byte(status_o, (prog_ctrl_pkg::STAT_POR_VALUE & prog_ctrl_pkg::STAT_KEEP_ON_WDT)
      | prog_ctrl_pkg::STAT_WDT_VALUE);
    chk_bit(int_enable_o, 1'b0);
    chk_bit(usb_addr_clear_o, 1'b1);
    @(negedge core_clk_i);
    chk_bit(usb_addr_clear_o, 1'b0);
    repeat (3) @(negedge core_clk_i);
    chk_byte(8'(n_wr - w0), 8'h00);
    status_clr_i = 8'h50;
    @(negedge core_clk_i);
    status_clr_i = 8'h00;
    chk_byte(status_o, 8'h01);
    p = rnd_pc();
    jump(p);
    target_i = rnd_pc();
    multi(prog_ctrl_pkg::OP_CALL);
    chk_byte(mem_at(8'h00), p[7:0]);
    push(v);
    chk_byte(mem_at(8'hFF), v);
    print_verdict();
  end
endmodule
